// ---- shared/acc_pkg.sv ----
// Purpose: Shared constants, field layouts and types of the converter control block.
// Assumes: System clock of 250 MHz (4 ns period).
// Notes:   Conversion-clock figures are counts of conversion clock enable pulses.
`default_nettype none

package acc_pkg;

  // System clock period and the start-up time of the async generator
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned ASYNC_START_US  = 5;
  localparam int unsigned ASYNC_START_CYC =
    (ASYNC_START_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Bus-clock part of the first-conversion adder
  localparam int unsigned FIRST_BUS_CYC = 5;
  localparam int unsigned WAKE_W        = 11;
  localparam logic [WAKE_W-1:0] WAKE_SHORT = WAKE_W'(FIRST_BUS_CYC - 1);
  localparam logic [WAKE_W-1:0] WAKE_LONG  = WAKE_W'(FIRST_BUS_CYC + ASYNC_START_CYC - 1);

  // Input clock select codes
  localparam logic [1:0] CLK_BUS      = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT      = 2'h2;
  localparam logic [1:0] CLK_ASYNC    = 2'h3;

  // Resolution mode codes
  localparam logic [1:0] MODE_8B  = 2'h0;
  localparam logic [1:0] MODE_12B = 2'h1;
  localparam logic [1:0] MODE_10B = 2'h2;

  // Channel code that switches the converter off
  localparam logic [4:0] CHAN_OFF = 5'h1f;

  // Conversion-clock cycle counts
  localparam int unsigned  CNT_W            = 6;
  localparam logic [5:0]   FIRST_CONVERSION_CLOCK_LONG  = 6'h03;
  localparam logic [5:0]   FIRST_CONVERSION_CLOCK_SHORT = 6'h05;
  localparam logic [5:0]   BCT_8B           = 6'h11;
  localparam logic [5:0]   BCT_HI           = 6'h14;
  localparam logic [5:0]   HSC_ADD          = 6'h04;
  localparam logic [5:0]   LST_00           = 6'h14;
  localparam logic [5:0]   LST_01           = 6'h0c;
  localparam logic [5:0]   LST_10           = 6'h06;
  localparam logic [5:0]   LST_11           = 6'h02;

  // Result reset value
  localparam logic [11:0] RESULT_RST = 12'h000;

  // Configuration fields held outside the main control register
  typedef struct packed {
    logic       low_power_cfg;
    logic [1:0] clock_divide_sel;
    logic       long_sample_sel;
    logic [1:0] sample_length_sel;
    logic [1:0] mode;
    logic [1:0] input_clock_sel;
    logic       high_speed_cfg;
    logic       async_clock_out_en;
    logic       hw_trigger_select;
    logic       compare_enable;
    logic       compare_greater_sel;
    logic       continuous_enable;
  } acc_cfg_t;

  // Main conversion control register
  typedef struct packed {
    logic       complete_irq_en;
    logic [4:0] channel_select;
  } acc_ctrl_t;

  localparam acc_ctrl_t CTRL_RST = '{complete_irq_en: 1'b0, channel_select: CHAN_OFF};

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WAKE    = 3'b001,
    ST_FIRST   = 3'b011,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b110
  } acc_state_t;

endpackage : acc_pkg

`default_nettype wire

// ---- design/acc_clk_div.sv ----
// Purpose: Divides the selected source enable into the conversion clock enable.
// Assumes: Source ticks are one-cycle enables on the system clock.
// Notes:   Ratio is 1, 2, 4 or 8 as picked by the divide select.
`default_nettype none

module acc_clk_div
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // Source and ratio
  input  wire logic       src_tick_in,
  input  wire logic [1:0] div_sel_in,
  // Divided enable
  output logic            tick_out
);

  logic [2:0] cnt_q;
  logic [2:0] mask;

  always_comb begin
    unique case (div_sel_in)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
  end

  assign tick_out = src_tick_in && ((cnt_q & mask) == mask);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cnt_q <= 3'h0;
    end else if (src_tick_in) begin
      cnt_q <= 3'(cnt_q + 3'h1);
    end
  end

endmodule // acc_clk_div

`default_nettype wire

// ---- design/acc_conv_ctrl.sv ----
// Purpose: Sequencer, abort handling, timing and compare of a SAR converter.
// Assumes: All inputs synchronous to clk_sys_in; analog core gives its code on sar_result_in.
// Notes:   Registers are plain ports; write strobes are one-cycle pulses.
//
// Function
// - Control register write aborts a running conversion; software mode restarts unless channel off.
// - Writing any other converter register aborts the running conversion.
// - Reset or deepest stop aborts and returns results to reset values.
// - Light stop aborts unless the async clock is the conversion clock.
// - Other aborts keep the result of the last good conversion.
// - Idle until triggered; async generator off unless needed or enabled.
// - Async output enable keeps the async generator running always.
// - Low-power bit puts the active converter in reduced-power setting.
// - Sample input, isolate, approximate, then move result to result registers.
// - Total time is first adder plus base, long-sample and high-speed adders.
// - First adder is 3 or 5 conversion clocks plus 5 bus, plus 5us cold async.
// - Base time is 17 clocks in 8-bit mode, 20 otherwise.
// - Long-sample adder is 0 short, else 20, 12, 6 or 2 clocks.
// - High-speed bit adds four conversion clocks per conversion.
// - Compare is result below value, or at-or-above when greater select set.
// - True compare sets the flag; false compare leaves flag and result untouched.
// - Interrupt raised when flag sets with completion interrupt enabled.
// - Compare keeps running in wait, and in light stop on the async clock only, to wake system.
// - Source clock divided by 1, 2, 4 or 8 into conversion clock.
// - Continuous mode starts the next conversion after each completion until aborted.
// - Converter disabled in reset, deepest stop, and with channel all ones.
`default_nettype none

module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int unsigned ASYNC_DIV = 2
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Register writes
  input  wire logic        ctrl_wr_in,
  input  wire acc_ctrl_t   ctrl_in,
  input  wire logic        other_wr_in,
  input  wire acc_cfg_t    cfg_in,
  input  wire logic [11:0] compare_value_in,
  // Power modes
  input  wire logic        deepest_stop_in,
  input  wire logic        light_stop_in,
  // Trigger and alternate clock
  input  wire logic        hw_trigger_in,
  input  wire logic        alt_clk_tick_in,
  // Analog core
  input  wire logic [11:0] sar_result_in,
  output logic             sample_out,
  output logic             convert_out,
  output logic             low_power_out,
  output logic             async_gen_run_out,
  output logic [4:0]       channel_out,
  // Status
  output logic [7:0]       result_high_out,
  output logic [7:0]       result_low_out,
  output logic             complete_flag_out,
  output logic             active_out,
  output logic             irq_out
);

  acc_state_t        state_q;
  acc_ctrl_t         ctrl_q;
  logic [WAKE_W-1:0] wake_cnt_q;
  logic [CNT_W-1:0]  conversion_clock_cnt_q;
  logic [11:0]       result_q;
  logic              flag_q;
  logic              hw_q;
  logic              half_q;
  logic [3:0]        async_cnt_q;

  logic              busy;
  logic              disabled;
  logic              stop_hold;
  logic              abort;
  logic              sw_start;
  logic              hw_start;
  logic              start;
  logic              async_tick;
  logic              src_tick;
  logic              conversion_clock;
  logic              cold_async;
  logic [5:0]        first_cyc;
  logic [5:0]        lst_cyc;
  logic [5:0]        conv_cyc;
  logic              done;
  logic              done_ok;
  logic              cmp_true;
  logic              xfer;

  assign busy     = (state_q != ST_IDLE);
  assign disabled = (ctrl_q.channel_select == CHAN_OFF);
  // Non-async clocks are stopped in light stop, so nothing may run on them
  assign stop_hold = light_stop_in && (cfg_in.input_clock_sel != CLK_ASYNC);

  assign abort = busy && (ctrl_wr_in || other_wr_in || stop_hold);

  assign sw_start = ctrl_wr_in && !cfg_in.hw_trigger_select &&
                    (ctrl_in.channel_select != CHAN_OFF);
  // Edges during a conversion are ignored; continuous series see only the first
  assign hw_start = cfg_in.hw_trigger_select && hw_trigger_in && !hw_q &&
                    !busy && !disabled && !ctrl_wr_in;
  assign start    = (sw_start || hw_start) && !stop_hold;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      hw_q <= 1'b0;
    end else begin
      hw_q <= hw_trigger_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || deepest_stop_in) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr_in) begin
      ctrl_q <= ctrl_in;
    end
  end

  assign async_gen_run_out = cfg_in.async_clock_out_en ||
                             (busy && (cfg_in.input_clock_sel == CLK_ASYNC));

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || !async_gen_run_out) begin
      async_cnt_q <= 4'h0;
    end else if (async_tick) begin
      async_cnt_q <= 4'h0;
    end else begin
      async_cnt_q <= 4'(async_cnt_q + 4'h1);
    end
  end
  assign async_tick = async_gen_run_out && (async_cnt_q == 4'(ASYNC_DIV - 1));

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      half_q <= 1'b0;
    end else begin
      half_q <= !half_q;
    end
  end

  always_comb begin
    unique case (cfg_in.input_clock_sel)
      CLK_BUS:      src_tick = !stop_hold;
      CLK_BUS_HALF: src_tick = half_q && !stop_hold;
      CLK_ALT:      src_tick = alt_clk_tick_in && !stop_hold;
      CLK_ASYNC:    src_tick = async_tick;
    endcase
  end

  acc_clk_div u_div (
    .clk_sys_in  (clk_sys_in),
    .rstn_in     (rstn_in),
    .src_tick_in (src_tick),
    .div_sel_in  (cfg_in.clock_divide_sel),
    .tick_out    (conversion_clock)
  );

  assign cold_async = (cfg_in.input_clock_sel == CLK_ASYNC) && !cfg_in.async_clock_out_en;
  assign first_cyc  = cfg_in.long_sample_sel ? FIRST_CONVERSION_CLOCK_LONG : FIRST_CONVERSION_CLOCK_SHORT;

  always_comb begin
    unique case (cfg_in.sample_length_sel)
      2'h0: lst_cyc = LST_00;
      2'h1: lst_cyc = LST_01;
      2'h2: lst_cyc = LST_10;
      2'h3: lst_cyc = LST_11;
    endcase
    if (!cfg_in.long_sample_sel) begin
      lst_cyc = 6'h00;
    end
  end

  assign conv_cyc = 6'((cfg_in.mode == MODE_8B ? BCT_8B : BCT_HI) +
                       (cfg_in.high_speed_cfg ? HSC_ADD : 6'h00));

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || deepest_stop_in) begin
      state_q    <= ST_IDLE;
      wake_cnt_q <= '0;
      conversion_clock_cnt_q <= '0;
    end else if (start) begin
      state_q    <= ST_WAKE;
      wake_cnt_q <= cold_async ? WAKE_LONG : WAKE_SHORT;
    end else if (abort) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        ST_WAKE: begin
          if (wake_cnt_q == '0) begin
            state_q    <= ST_FIRST;
            conversion_clock_cnt_q <= 6'(first_cyc - 6'h01);
          end else begin
            wake_cnt_q <= WAKE_W'(wake_cnt_q - 1'b1);
          end
        end
        ST_FIRST, ST_SAMPLE: begin
          if (conversion_clock && conversion_clock_cnt_q == '0) begin
            if (state_q == ST_FIRST && lst_cyc != 6'h00) begin
              state_q    <= ST_SAMPLE;
              conversion_clock_cnt_q <= 6'(lst_cyc - 6'h01);
            end else begin
              state_q    <= ST_CONVERT;
              conversion_clock_cnt_q <= 6'(conv_cyc - 6'h01);
            end
          end else if (conversion_clock) begin
            conversion_clock_cnt_q <= 6'(conversion_clock_cnt_q - 6'h01);
          end
        end
        ST_CONVERT: begin
          if (done) begin
            if (cfg_in.continuous_enable && lst_cyc != 6'h00) begin
              state_q    <= ST_SAMPLE;
              conversion_clock_cnt_q <= 6'(lst_cyc - 6'h01);
            end else if (cfg_in.continuous_enable) begin
              conversion_clock_cnt_q <= 6'(conv_cyc - 6'h01);
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (conversion_clock) begin
            conversion_clock_cnt_q <= 6'(conversion_clock_cnt_q - 6'h01);
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign done    = (state_q == ST_CONVERT) && conversion_clock && (conversion_clock_cnt_q == '0);
  assign done_ok = done && !abort && !start && !deepest_stop_in;

  assign cmp_true = !cfg_in.compare_enable ||
                    (cfg_in.compare_greater_sel ? (sar_result_in >= compare_value_in)
                                                : (sar_result_in <  compare_value_in));
  assign xfer = done_ok && cmp_true;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || deepest_stop_in) begin
      result_q <= RESULT_RST;
    end else if (xfer) begin
      result_q <= sar_result_in;
    end
  end

  // flag on completion
  // A control write in the completion cycle aborts it, so the clear wins over the set
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || deepest_stop_in) begin
      flag_q <= 1'b0;
    end else if (xfer) begin
      flag_q <= 1'b1;
    end else if (ctrl_wr_in) begin
      flag_q <= 1'b0;
    end
  end

  assign irq_out           = flag_q && ctrl_q.complete_irq_en;
  assign complete_flag_out = flag_q;
  assign result_high_out   = {4'h0, result_q[11:8]};
  assign result_low_out    = result_q[7:0];
  assign active_out        = busy;
  assign channel_out       = ctrl_q.channel_select;
  assign sample_out        = (state_q == ST_FIRST) || (state_q == ST_SAMPLE);
  assign convert_out       = (state_q == ST_CONVERT);
  assign low_power_out     = cfg_in.low_power_cfg && busy;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  logic quiet;
  assign quiet = !ctrl_wr_in && !other_wr_in && !light_stop_in && !deepest_stop_in;

  sequence s_wake_tail;
    (state_q == ST_WAKE && wake_cnt_q == WAKE_SHORT && quiet) ##1 quiet [*4];
  endsequence

  property p_ctrl_restart;
    busy && sw_start && !stop_hold && !deepest_stop_in |=> state_q == ST_WAKE;
  endproperty
  a_ctrl_restart: assert property (p_ctrl_restart) else $error("restart after write missing");

  property p_other_abort;
    busy && other_wr_in && !start && !deepest_stop_in |=> state_q == ST_IDLE && $stable(flag_q);
  endproperty
  a_other_abort: assert property (p_other_abort) else $error("other write did not abort");

  property p_deep_reset;
    deepest_stop_in |=> result_q == RESULT_RST && !flag_q && state_q == ST_IDLE;
  endproperty
  a_deep_reset: assert property (p_deep_reset) else $error("deepest stop did not clear");

  property p_light_abort;
    busy && stop_hold && !deepest_stop_in |=> state_q == ST_IDLE;
  endproperty
  a_light_abort: assert property (p_light_abort) else $error("light stop did not abort");

  property p_abort_keeps;
    abort && !deepest_stop_in |=> $stable(result_q);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort altered result");

  property p_gen_idle;
    !busy && !cfg_in.async_clock_out_en |-> !async_gen_run_out;
  endproperty
  a_gen_idle: assert property (p_gen_idle) else $error("async generator ran while idle");

  property p_gen_on;
    cfg_in.async_clock_out_en |-> async_gen_run_out;
  endproperty
  a_gen_on: assert property (p_gen_on) else $error("async generator stopped");

  property p_wake_len;
    s_wake_tail |=> state_q == ST_FIRST;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("bus part of first adder wrong");

  property p_xfer;
    xfer |=> result_q == $past(sar_result_in) && flag_q;
  endproperty
  a_xfer: assert property (p_xfer) else $error("result not transferred");

  property p_cmp_false;
    done_ok && !cmp_true |=> $stable(result_q) && flag_q == $past(flag_q);
  endproperty
  a_cmp_false: assert property (p_cmp_false) else $error("false compare changed state");

  property p_irq;
    xfer && ctrl_q.complete_irq_en && !ctrl_wr_in |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_chan_off;
    ctrl_wr_in && ctrl_in.channel_select == CHAN_OFF && !hw_start |=> state_q == ST_IDLE;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("channel off still converting");

  property p_cont;
    done_ok && cfg_in.continuous_enable |=> state_q inside {ST_SAMPLE, ST_CONVERT};
  endproperty
  a_cont: assert property (p_cont) else $error("continuous series stopped");

endmodule // acc_conv_ctrl

`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench of the converter control block.
// Assumes: Async generator ticks every system cycle (ASYNC_DIV of 1).
// Notes:   Counts start in the first cycle after a control write.
`default_nettype none

module testbench
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys_in       = 1'b0;
  logic        rstn_in          = 1'b0;
  logic        ctrl_wr_in       = 1'b0;
  acc_ctrl_t   ctrl_in          = CTRL_RST;
  logic        other_wr_in      = 1'b0;
  acc_cfg_t    cfg_in           = '0;
  logic [11:0] compare_value_in = 12'h000;
  logic        deepest_stop_in  = 1'b0;
  logic        light_stop_in    = 1'b0;
  logic        hw_trigger_in    = 1'b0;
  logic        alt_clk_tick_in  = 1'b0;
  logic [11:0] sar_result_in    = 12'h000;
  logic        sample_out;
  logic        convert_out;
  logic        low_power_out;
  logic        async_gen_run_out;
  logic [4:0]  channel_out;
  logic [7:0]  result_high_out;
  logic [7:0]  result_low_out;
  logic        complete_flag_out;
  logic        active_out;
  logic        irq_out;
  int          failures         = 0;
  int          checks_done      = 0;
  int          lst_tab [4]      = '{20, 12, 6, 2};
  // Last value that legally reached the result registers
  logic [11:0] kept             = 12'h000;

  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) alt_clk_tick_in <= ~alt_clk_tick_in;

  acc_conv_ctrl #(.ASYNC_DIV(1)) acc_conv_ctrl_i (
    .clk_sys_in, .rstn_in, .ctrl_wr_in, .ctrl_in, .other_wr_in, .cfg_in,
    .compare_value_in, .deepest_stop_in, .light_stop_in, .hw_trigger_in,
    .alt_clk_tick_in, .sar_result_in, .sample_out, .convert_out, .low_power_out,
    .async_gen_run_out, .channel_out, .result_high_out, .result_low_out,
    .complete_flag_out, .active_out, .irq_out
  );

  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_result(input logic [11:0] exp);
    chk({16'h0000, result_high_out, result_low_out}, {20'h00000, exp});
  endtask

  task automatic wr_ctrl(input logic irq, input logic [4:0] chan);
    ctrl_in    = '{complete_irq_en: irq, channel_select: chan};
    ctrl_wr_in = 1'b1;
    tick();
    ctrl_wr_in = 1'b0;
  endtask

  // Bounded wait; a hang shows up as a wrong count
  task automatic wait_done(output int k);
    k = 0;
    while (complete_flag_out !== 1'b1 && k < 3000) begin
      tick();
      k++;
    end
  endtask

  task automatic give_verdict();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk_result(RESULT_RST);
    chk({complete_flag_out, active_out, irq_out}, 3'b000);
    chk(channel_out, CHAN_OFF);
  endtask

  task automatic t_walk();
    cfg_in.low_power_cfg = 1'b1;
    sar_result_in = 12'h5a3;
    wr_ctrl(1'b1, 5'h01);
    chk(active_out, 1'b1);
    repeat (7) tick();
    chk({sample_out, convert_out, low_power_out}, 3'b101);
    repeat (13) tick();
    chk({sample_out, convert_out}, 2'b01);
    repeat (9) tick();
    chk(complete_flag_out, 1'b0);
    tick();
    chk({complete_flag_out, irq_out, active_out, low_power_out}, 4'hc);
    chk_result(12'h5a3);
    cfg_in.low_power_cfg = 1'b0;
  endtask

  task automatic t_timing();
    int k;
    int s;
    int e;
    for (int j = 0; j < 20; j++) begin
      s = j / 4;
      cfg_in.high_speed_cfg    = j[0];
      cfg_in.mode              = j[1] ? MODE_8B : MODE_12B;
      cfg_in.long_sample_sel   = (s != 0);
      cfg_in.sample_length_sel = 2'(s - 1);
      e = 5 + ((s != 0) ? 3 + lst_tab[s-1] : 5) + (j[1] ? 17 : 20) + (j[0] ? 4 : 0);
      kept = 12'(j * 197);
      sar_result_in = kept;
      wr_ctrl(1'b0, 5'h03);
      wait_done(k);
      chk(k, e);
      chk_result(kept);
    end
    cfg_in.high_speed_cfg  = 1'b0;
    cfg_in.mode            = MODE_10B;
    cfg_in.long_sample_sel = 1'b0;
  endtask

  task automatic t_restart();
    int k;
    wr_ctrl(1'b0, 5'h02);
    repeat (10) tick();
    sar_result_in = 12'h3c1;
    wr_ctrl(1'b0, 5'h04);
    wait_done(k);
    chk(k, 30);
    chk(channel_out, 5'h04);
    kept = 12'h3c1;
  endtask

  task automatic t_abort();
    for (int i = 0; i < 4; i++) begin
      sar_result_in = 12'hfff;
      wr_ctrl(1'b1, 5'h01);
      repeat (12) tick();
      case (i)
        0: begin
          other_wr_in = 1'b1;
          tick();
          other_wr_in = 1'b0;
        end
        1: wr_ctrl(1'b1, CHAN_OFF);
        2: begin
          light_stop_in = 1'b1;
          repeat (3) tick();
          light_stop_in = 1'b0;
        end
        default: begin
          deepest_stop_in = 1'b1;
          repeat (3) tick();
          deepest_stop_in = 1'b0;
        end
      endcase
      chk(active_out, 1'b0);
      repeat (40) tick();
      chk({complete_flag_out, irq_out, active_out}, 3'b000);
      if (i == 3) kept = RESULT_RST;
      chk_result(kept);
    end
    chk(channel_out, CHAN_OFF);
  endtask

  task automatic t_compare();
    logic [11:0] sar_tab [4] = '{12'h1ff, 12'h200, 12'h200, 12'h1ff};
    logic        hit;
    cfg_in.compare_enable = 1'b1;
    compare_value_in = 12'h200;
    for (int i = 0; i < 4; i++) begin
      cfg_in.compare_greater_sel = i[1];
      sar_result_in = sar_tab[i];
      hit = i[1] ? (sar_tab[i] >= 12'h200) : (sar_tab[i] < 12'h200);
      wr_ctrl(1'b1, 5'h05);
      repeat (40) tick();
      chk({complete_flag_out, irq_out, active_out}, {hit, hit, 1'b0});
      if (hit) kept = sar_tab[i];
      chk_result(kept);
    end
    cfg_in.compare_enable = 1'b0;
    cfg_in.compare_greater_sel = 1'b0;
  endtask

  task automatic t_cont();
    int k;
    cfg_in.continuous_enable = 1'b1;
    sar_result_in = 12'h111;
    wr_ctrl(1'b0, 5'h06);
    wait_done(k);
    chk(k, 30);
    sar_result_in = 12'h222;
    k = 0;
    while (result_low_out !== 8'h22 && k < 100) begin
      tick();
      k++;
    end
    chk(k, 20);
    chk(active_out, 1'b1);
    other_wr_in = 1'b1;
    tick();
    other_wr_in = 1'b0;
    cfg_in.continuous_enable = 1'b0;
    repeat (30) tick();
    chk({active_out, result_low_out}, 9'h022);
    kept = 12'h222;
  endtask

  task automatic t_async();
    int k;
    cfg_in.input_clock_sel = CLK_ASYNC;
    tick();
    chk(async_gen_run_out, 1'b0);
    sar_result_in = 12'h0f0;
    wr_ctrl(1'b0, 5'h07);
    chk(async_gen_run_out, 1'b1);
    wait_done(k);
    chk(k, 30 + ASYNC_START_CYC);
    tick();
    chk(async_gen_run_out, 1'b0);
    cfg_in.async_clock_out_en  = 1'b1;
    cfg_in.compare_enable      = 1'b1;
    cfg_in.compare_greater_sel = 1'b1;
    compare_value_in = 12'h000;
    // Generator warmed up for the start-up time before starting
    repeat (ASYNC_START_CYC) tick();
    chk(async_gen_run_out, 1'b1);
    wr_ctrl(1'b1, 5'h07);
    light_stop_in = 1'b1;
    wait_done(k);
    chk(k, 30);
    chk({irq_out, async_gen_run_out, active_out}, 3'b110);
    light_stop_in = 1'b0;
    cfg_in.input_clock_sel     = CLK_BUS;
    cfg_in.async_clock_out_en  = 1'b0;
    cfg_in.compare_enable      = 1'b0;
    cfg_in.compare_greater_sel = 1'b0;
    kept = 12'h0f0;
  endtask

  // Continuous period is 20 conversion clocks of the divided source
  task automatic t_div();
    int k;
    int src_per [4] = '{1, 2, 2, 1};
    cfg_in.continuous_enable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg_in.input_clock_sel  = 2'(i);
      cfg_in.clock_divide_sel = 2'(i);
      sar_result_in = 12'h055;
      wr_ctrl(1'b0, 5'h09);
      wait_done(k);
      sar_result_in = 12'h0aa;
      k = 0;
      while (result_low_out !== 8'haa && k < 400) begin
        tick();
        k++;
      end
      chk(k, 20 * src_per[i] * (1 << i));
      other_wr_in = 1'b1;
      tick();
      other_wr_in = 1'b0;
    end
    cfg_in.continuous_enable = 1'b0;
    cfg_in.input_clock_sel   = CLK_BUS;
    cfg_in.clock_divide_sel  = 2'h0;
    kept = 12'h0aa;
  endtask

  task automatic t_hw();
    int k;
    cfg_in.hw_trigger_select = 1'b1;
    sar_result_in = 12'h9e7;
    wr_ctrl(1'b0, 5'h08);
    repeat (3) tick();
    chk(active_out, 1'b0);
    hw_trigger_in = 1'b1;
    wait_done(k);
    chk({complete_flag_out, result_low_out}, 9'h1e7);
    repeat (5) tick();
    chk(active_out, 1'b0);
    hw_trigger_in = 1'b0;
    cfg_in.hw_trigger_select = 1'b0;
  endtask

  initial begin
    cfg_in.mode = MODE_10B;
    repeat (8) tick();
    rstn_in = 1'b1;
    t_reset();
    t_walk();
    t_timing();
    t_restart();
    t_abort();
    t_compare();
    t_cont();
    t_async();
    t_div();
    t_hw();
    wr_ctrl(1'b0, 5'h02);
    repeat (10) tick();
    rstn_in = 1'b0;
    repeat (2) tick();
    rstn_in = 1'b1;
    tick();
    t_reset();
    give_verdict();
  end

  // Whole run needs roughly 6200 cycles
  initial begin
    #100000;
    failures++;
    give_verdict();
  end

endmodule // testbench

`default_nettype wire
